// [emc_pkg.sv]
// constants shared by the multi-bit ecc capture block
//
// Overview of operation
// RL1: detect multi-bit data errors, never correct them
// RL2: capture visible only with multi-bit interrupt enabled
// RL3: capture aligned failing address offset
// RL4: capture erroneous data word, 64 or 32
// RL5: record privilege, requester, read/write for coupled memories
// RL6: size field fixed 64 instruction, 32 data
// RL7: syndrome not meaningful for multi-bit errors
// RL8: module and coupled ports share core clock
// RL9: on-chip RAM synchronous, divided from bus clock
// RL10: registers reached over register bus clock
// RL11: on-chip RAM runs at fixed 1:4 ratio
// RL12: up to three power sub-domains
// RL13: domain states follow low-power mode table
// RL14: bank 0 retention, 1-7 core, 8-15 gated
// RL15: single domain switched off via isolation
// RL16: code computed and checked every access
// RL17: status flag set only when status-enabled
// RL18: enabled errors ORed into one interrupt
// RL19: status flags clear on write one
// RL20: capture updates per error, holds otherwise
package emc_pkg;
  // ======
  // channels: 0 on-chip RAM, 1 instruction, 2 even, 3 odd half
  // ======
  localparam int NCH = 4;
  localparam int CH_SR = 0;
  localparam int CH_IC = 1;
  // ======
  // register map (byte addresses)
  // ======
  localparam logic [7:0] A_ECC_EN = 8'h00;
  localparam logic [7:0] A_STAT_EN = 8'h04;
  localparam logic [7:0] A_SIG_EN = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_PWR_CTL = 8'h10;
  localparam logic [7:0] A_PWR_STAT = 8'h14;
  // capture window 0x40..0x7F: addr[5:4] channel, addr[3:2] field
  localparam logic [1:0] CAP_SEL = 2'h1;
  localparam logic [1:0] F_ADDR = 2'h0;
  localparam logic [1:0] F_DLO = 2'h1;
  localparam logic [1:0] F_DHI = 2'h2;
  localparam logic [1:0] F_INFO = 2'h3;
  // reset values
  localparam logic [3:0] RST_EN = 4'h0;
  localparam logic [2:0] RST_PWR_CTL = 3'h7;
  // power control bits
  localparam int PC_KEEP = 0;
  localparam int PC_GATED = 1;
  localparam int PC_SINGLE = 2;
  // ======
  // error information layout
  // ======
  localparam int INFO_PRIV = 0;
  localparam int INFO_REQ = 1;
  localparam int INFO_WR = 3;
  localparam int INFO_SIZE = 4;
  localparam logic [1:0] SIZE_64 = 2'h3;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam int ALIGN_64 = 3;
  localparam int ALIGN_32 = 2;
  // ======
  // bus answers, clock ratio, modes, banks
  // ======
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SR_DIV_LAST = 2'h3;
  localparam logic [1:0] MODE_SYS_IDLE = 2'h0;
  localparam logic [1:0] MODE_LP_IDLE = 2'h1;
  localparam logic [1:0] MODE_SUSPEND = 2'h2;
  localparam logic [1:0] MODE_BATTERY = 2'h3;
  localparam int RET_LAST = 0;
  localparam int CORE_LAST = 7;
endpackage : emc_pkg

// [emc_code.sv]
// check-code generator and multi-bit detector for one word width
`timescale 1ns/1ps
`default_nettype none
module emc_code #(
  parameter int DW = 64
) (
  input wire logic [DW-1:0] data,
  input wire logic [7:0] check,
  output logic [7:0] gen,
  output logic multi,
  output logic single
);
  // ==========================================================
  // extended hamming: bits 6:0 position code, bit 7 parity
  // ==========================================================
  logic [7:0] syn; // difference of stored and fresh code
  logic par; // overall parity of the received word

  // position code: data bit k weighs k+1, so flipping two data bits
  // always leaves a nonzero position code with even parity
  always_comb begin
    gen = 8'h00;
    for (int k = 0; k < DW; k++) begin
      for (int j = 0; j < 7; j++) begin
        if (((k + 1) >> j) % 2 == 1) begin
          gen[j] = gen[j] ^ data[k];
        end
      end
    end
    gen[7] = (^data) ^ (^gen[6:0]);
    syn = gen ^ check;
    par = (^data) ^ (^check);
    multi = (syn[6:0] != 7'h00) && !par; // [RL1]
    single = par; // flagged only, no correction here [RL1]
  end
endmodule : emc_code
`default_nettype wire

// [emc_power.sv]
// power sub-domain and bank switching for the ram array
`timescale 1ns/1ps
`default_nettype none
module emc_power #(
  parameter bit THREE_DOMAIN = 1'b1,
  parameter int BANKS = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lp_mode,
  input wire logic [2:0] ctl,
  output logic [2:0] dom_on,
  output logic [2:0] dom_iso,
  output logic [BANKS-1:0] bank_on
);
  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [2:0] on; // retention, core-following, gated
    logic [BANKS-1:0] banks;
  } emc_pwr_state_t;
  emc_pwr_state_t q_reg;
  emc_pwr_state_t q_next;
  logic [BANKS-1:0] bank_w; // per-bank power from its domain

  // each bank follows the domain it belongs to
  generate
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
      if (!THREE_DOMAIN) begin : g_one
        assign bank_w[b] = q_next.on[0]; // [RL15]
      end else if (b <= emc_pkg::RET_LAST) begin : g_ret
        assign bank_w[b] = q_next.on[0]; // [RL14]
      end else if (b <= emc_pkg::CORE_LAST) begin : g_core
        assign bank_w[b] = q_next.on[1]; // [RL14]
      end else begin : g_gate
        assign bank_w[b] = q_next.on[2]; // [RL14]
      end
    end
  endgenerate

  // domain state per low-power mode
  always_comb begin
    q_next = q_reg;
    q_next.on = 3'h0;
    if (THREE_DOMAIN) begin
      case (lp_mode)
        emc_pkg::MODE_SYS_IDLE, emc_pkg::MODE_LP_IDLE: begin
          q_next.on[0] = 1'b1; // [RL13]
          q_next.on[1] = 1'b1; // [RL13]
          q_next.on[2] = ctl[emc_pkg::PC_GATED]; // [RL13]
        end
        emc_pkg::MODE_SUSPEND: begin
          q_next.on[0] = 1'b1; // [RL13]
          q_next.on[1] = ctl[emc_pkg::PC_KEEP]; // [RL13]
        end
        default: begin
          q_next.on = 3'h0; // battery-backed: all off [RL13]
        end
      endcase
    end else begin
      // one shared domain, cut by the isolation switch [RL15]
      q_next.on[0] = (lp_mode != emc_pkg::MODE_BATTERY)
                     && ctl[emc_pkg::PC_SINGLE];
    end
    q_next.banks = bank_w;
  end

  // registered so the switches never glitch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign dom_on = q_reg.on; // [RL12]
  assign dom_iso = ~q_reg.on;
  assign bank_on = q_reg.banks;
endmodule : emc_power
`default_nettype wire

// [emc_top.sv]
// multi-bit ecc error capture with register slave and power control
`timescale 1ns/1ps
`default_nettype none
module emc_top #(
  parameter int AW = 20,
  parameter bit THREE_DOMAIN = 1'b1,
  parameter int BANKS = 16
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  // register slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // on-chip ram port, taken on the slow enable
  input wire logic SR_VALID,
  output logic SR_READY,
  input wire logic SR_WRITE,
  input wire logic [AW-1:0] SR_ADDR,
  input wire logic [63:0] SR_DATA,
  input wire logic [7:0] SR_CHECK,
  output logic [7:0] SR_GEN_CHECK,
  // instruction coupled port
  input wire logic IC_VALID,
  input wire logic IC_WRITE,
  input wire logic [AW-1:0] IC_ADDR,
  input wire logic [63:0] IC_DATA,
  input wire logic [7:0] IC_CHECK,
  input wire logic IC_PRIV,
  input wire logic [1:0] IC_REQ,
  output logic [7:0] IC_GEN_CHECK,
  // data coupled even half
  input wire logic DCE_VALID,
  input wire logic DCE_WRITE,
  input wire logic [AW-1:0] DCE_ADDR,
  input wire logic [31:0] DCE_DATA,
  input wire logic [7:0] DCE_CHECK,
  input wire logic DCE_PRIV,
  input wire logic [1:0] DCE_REQ,
  output logic [7:0] DCE_GEN_CHECK,
  // data coupled odd half
  input wire logic DCO_VALID,
  input wire logic DCO_WRITE,
  input wire logic [AW-1:0] DCO_ADDR,
  input wire logic [31:0] DCO_DATA,
  input wire logic [7:0] DCO_CHECK,
  input wire logic DCO_PRIV,
  input wire logic [1:0] DCO_REQ,
  output logic [7:0] DCO_GEN_CHECK,
  // power
  input wire logic [1:0] LP_MODE,
  output logic [2:0] DOMAIN_ON,
  output logic [2:0] DOMAIN_ISO,
  output logic [BANKS-1:0] BANK_PWR_ON,
  // single interrupt request
  output logic IRQ
);
  // ======
  // state: one packed struct
  // ======
  localparam int NCH_L = emc_pkg::NCH;
  typedef struct packed {
    logic aw_full; // write address held
    logic [7:0] aw_addr;
    logic w_full; // write data held
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ecc_en; // per channel ecc enable
    logic [3:0] stat_en; // status enable
    logic [3:0] sig_en; // interrupt enable
    logic [3:0] status; // sticky multi-bit flags
    logic [2:0] pwr_ctl;
    logic [1:0] div; // slow ram divider
    logic irq;
    logic [NCH_L-1:0][AW-1:0] cap_addr;
    logic [NCH_L-1:0][63:0] cap_data;
    logic [NCH_L-1:0][7:0] cap_info;
    logic [NCH_L-1:0][7:0] gen;
  } emc_top_state_t;

  emc_top_state_t q_reg;
  emc_top_state_t q_next;

  // ======
  // channel gathering
  // ======
  logic tick; // one cycle in four, the slow ram rate
  logic [NCH_L-1:0] acc; // access taken this cycle
  logic [NCH_L-1:0] wr;
  logic [NCH_L-1:0] prv;
  logic [NCH_L-1:0][1:0] req;
  logic [NCH_L-1:0][AW-1:0] addr;
  logic [NCH_L-1:0][63:0] data;
  logic [NCH_L-1:0][7:0] chk;
  logic [NCH_L-1:0][7:0] gen_w;
  logic [NCH_L-1:0] multi_w;
  logic [2:0] dom_on_w;

  // ram side runs synchronous to the bus at a fixed 1:4 ratio,
  // so it is an enable, not a second clock [RL9] [RL11]
  assign tick = (q_reg.div == emc_pkg::SR_DIV_LAST);
  assign SR_READY = tick;

  // coupled ports all on the core clock [RL8]
  assign acc = {DCO_VALID, DCE_VALID, IC_VALID, SR_VALID && tick};
  assign wr = {DCO_WRITE, DCE_WRITE, IC_WRITE, SR_WRITE};
  assign prv = {DCO_PRIV, DCE_PRIV, IC_PRIV, 1'b0};
  assign req = {DCO_REQ, DCE_REQ, IC_REQ, 2'h0};
  assign addr = {DCO_ADDR, DCE_ADDR, IC_ADDR, SR_ADDR};
  assign data = {32'h0, DCO_DATA, 32'h0, DCE_DATA, IC_DATA, SR_DATA};
  assign chk = {DCO_CHECK, DCE_CHECK, IC_CHECK, SR_CHECK};

  // one checker per channel, wide or half width
  generate
    for (genvar c = 0; c < NCH_L; c++) begin : g_chk
      if (c <= emc_pkg::CH_IC) begin : g_w64
        emc_code #(.DW(64)) u_code (
          .data(data[c]),
          .check(chk[c]),
          .gen(gen_w[c]),
          .multi(multi_w[c]),
          .single()
        );
      end else begin : g_w32
        emc_code #(.DW(32)) u_code (
          .data(data[c][31:0]),
          .check(chk[c]),
          .gen(gen_w[c]),
          .multi(multi_w[c]),
          .single()
        );
      end
    end
  endgenerate

  // power sub-domains
  emc_power #(.THREE_DOMAIN(THREE_DOMAIN), .BANKS(BANKS)) u_power (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .lp_mode(LP_MODE),
    .ctl(q_reg.pwr_ctl),
    .dom_on(dom_on_w),
    .dom_iso(DOMAIN_ISO),
    .bank_on(BANK_PWR_ON)
  );
  assign DOMAIN_ON = dom_on_w;

  // ======
  // helpers
  // ======
  // known word address of the map
  function automatic logic hit(input logic [7:0] a);
    hit = (a[1:0] == 2'h0) && ((a[7:6] == emc_pkg::CAP_SEL)
          || (a <= emc_pkg::A_PWR_STAT));
  endfunction : hit

  // byte-lane merge for a small register in lane 0
  function automatic logic [3:0] lane0(input logic [3:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[3:0] : old;
  endfunction : lane0

  // read multiplexer
  function automatic logic [31:0] rd(input emc_top_state_t s,
                                     input logic [7:0] a,
                                     input logic [2:0] dom);
    logic [1:0] ch;
    ch = a[5:4];
    rd = 32'h0;
    if (a[7:6] == emc_pkg::CAP_SEL) begin
      case (a[3:2])
        emc_pkg::F_ADDR: rd = 32'(s.cap_addr[ch]); // [RL3]
        emc_pkg::F_DLO: rd = s.cap_data[ch][31:0]; // [RL4]
        emc_pkg::F_DHI: rd = s.cap_data[ch][63:32]; // [RL4]
        default: rd = {24'h0, s.cap_info[ch]}; // [RL5]
      endcase
    end else begin
      case (a)
        emc_pkg::A_ECC_EN: rd = {28'h0, s.ecc_en};
        emc_pkg::A_STAT_EN: rd = {28'h0, s.stat_en};
        emc_pkg::A_SIG_EN: rd = {28'h0, s.sig_en};
        emc_pkg::A_STATUS: rd = {28'h0, s.status};
        emc_pkg::A_PWR_CTL: rd = {29'h0, s.pwr_ctl};
        emc_pkg::A_PWR_STAT: rd = {29'h0, dom};
        default: rd = 32'h0;
      endcase
    end
  endfunction : rd

  // ======
  // next state
  // ======
  // registers over the bus, on the bus clock [RL10]
  always_comb begin
    q_next = q_reg;
    q_next.div = tick ? 2'h0 : q_reg.div + 2'h1;
    // write address and data taken in either order
    if (AWVALID && AWREADY) begin
      q_next.aw_full = 1'b1;
      q_next.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      q_next.w_full = 1'b1;
      q_next.w_data = WDATA;
      q_next.w_strb = WSTRB;
    end
    if (BVALID && BREADY) begin
      q_next.bvalid = 1'b0;
    end
    // both halves held: perform the write, then answer
    if (q_reg.aw_full && q_reg.w_full && !q_reg.bvalid) begin
      q_next.aw_full = 1'b0;
      q_next.w_full = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp = hit(q_reg.aw_addr) ? emc_pkg::RESP_OKAY
                                        : emc_pkg::RESP_SLVERR;
      case (q_reg.aw_addr)
        emc_pkg::A_ECC_EN: begin
          q_next.ecc_en = lane0(q_reg.ecc_en, q_reg.w_data, q_reg.w_strb);
        end
        emc_pkg::A_STAT_EN: begin
          q_next.stat_en = lane0(q_reg.stat_en, q_reg.w_data, q_reg.w_strb);
        end
        emc_pkg::A_SIG_EN: begin
          q_next.sig_en = lane0(q_reg.sig_en, q_reg.w_data, q_reg.w_strb);
        end
        emc_pkg::A_STATUS: begin
          // ones clear, zeros leave the flag alone [RL19]
          if (q_reg.w_strb[0]) begin
            q_next.status = q_reg.status & ~q_reg.w_data[3:0];
          end
        end
        emc_pkg::A_PWR_CTL: begin
          if (q_reg.w_strb[0]) begin
            q_next.pwr_ctl = q_reg.w_data[2:0];
          end
        end
        default: begin
          // read-only or unmapped: nothing stored
        end
      endcase
    end
    // read path: one outstanding read
    if (RVALID && RREADY) begin
      q_next.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      q_next.rvalid = 1'b1;
      q_next.rdata = rd(q_reg, ARADDR, dom_on_w);
      q_next.rresp = hit(ARADDR) ? emc_pkg::RESP_OKAY
                                 : emc_pkg::RESP_SLVERR;
    end
    // error detection per channel
    for (int c = 0; c < NCH_L; c++) begin
      if (acc[c] && q_reg.ecc_en[c]) begin
        // code offered back on every access, read or write [RL16]
        q_next.gen[c] = gen_w[c];
        if (multi_w[c]) begin
          // flag applied after the clear, so a new error wins [RL17]
          if (q_reg.stat_en[c]) begin
            q_next.status[c] = 1'b1;
          end
          // capture only when software can see it [RL2] [RL20]
          if (q_reg.sig_en[c]) begin
            q_next.cap_addr[c] = addr[c];
            if (c <= emc_pkg::CH_IC) begin
              q_next.cap_addr[c][emc_pkg::ALIGN_64-1:0] = '0; // [RL3]
            end else begin
              q_next.cap_addr[c][emc_pkg::ALIGN_32-1:0] = '0; // [RL3]
            end
            q_next.cap_data[c] = data[c]; // raw word kept [RL4]
            q_next.cap_info[c] = 8'h00; // syndrome not reported [RL7]
            if (c != emc_pkg::CH_SR) begin
              q_next.cap_info[c][emc_pkg::INFO_PRIV] = prv[c]; // [RL5]
              q_next.cap_info[c][emc_pkg::INFO_REQ+:2] = req[c]; // [RL5]
              q_next.cap_info[c][emc_pkg::INFO_WR] = wr[c]; // [RL5]
              q_next.cap_info[c][emc_pkg::INFO_SIZE+:2] =
                (c == emc_pkg::CH_IC) ? emc_pkg::SIZE_64
                                      : emc_pkg::SIZE_32; // [RL6]
            end
          end
        end
      end
    end
    // all enabled flags merge into one request [RL18]
    q_next.irq = |(q_next.status & q_next.sig_en);
  end

  // ======
  // state register
  // ======
  // synchronous reset to constants only
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      q_reg <= '0;
      q_reg.ecc_en <= emc_pkg::RST_EN;
      q_reg.pwr_ctl <= emc_pkg::RST_PWR_CTL;
    end else begin
      q_reg <= q_next;
    end
  end

  // ======
  // outputs
  // ======
  // ready terms are combinational, data from flip-flops
  assign AWREADY = !q_reg.aw_full;
  assign WREADY = !q_reg.w_full;
  assign BVALID = q_reg.bvalid;
  assign BRESP = q_reg.bresp;
  assign ARREADY = !q_reg.rvalid;
  assign RVALID = q_reg.rvalid;
  assign RDATA = q_reg.rdata;
  assign RRESP = q_reg.rresp;
  assign SR_GEN_CHECK = q_reg.gen[0];
  assign IC_GEN_CHECK = q_reg.gen[1];
  assign DCE_GEN_CHECK = q_reg.gen[2];
  assign DCO_GEN_CHECK = q_reg.gen[3];
  assign IRQ = q_reg.irq;
endmodule : emc_top
`default_nettype wire

// [emc_chk.sv]
// port-level assertions for the multi-bit ecc capture block
`timescale 1ns/1ps
`default_nettype none
module emc_chk #(
  parameter int BANKS = 16
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic SR_VALID,
  input wire logic SR_READY,
  input wire logic [1:0] LP_MODE,
  input wire logic [2:0] DOMAIN_ON,
  input wire logic [2:0] DOMAIN_ISO,
  input wire logic [BANKS-1:0] BANK_PWR_ON,
  input wire logic IRQ
);
  // ======
  // single clock domain, sync reset
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // ======
  // power domains and banks
  bank_map_a: assert property (
    BANK_PWR_ON[15:0] == {{8{DOMAIN_ON[2]}}, {7{DOMAIN_ON[1]}}, DOMAIN_ON[0]})
    else $error("bank power mismatch");
  iso_inverse_a: assert property (DOMAIN_ISO == ~DOMAIN_ON)
    else $error("isolation mismatch");
  battery_all_off_a: assert property (LP_MODE == 2'h3 |=> DOMAIN_ON == 3'h0)
    else $error("domain on in battery mode");
  retention_kept_a: assert property (LP_MODE != 2'h3 |=> DOMAIN_ON[0])
    else $error("retention domain off");
  idle_core_on_a: assert property (LP_MODE < 2'h2 |=> DOMAIN_ON[1])
    else $error("core domain off in idle");
  suspend_gated_a: assert property (LP_MODE == 2'h2 |=> !DOMAIN_ON[2])
    else $error("gated domain on in suspend");
  // ======
  // slow ram port tick: one in four cycles
  ram_tick_a: assert property (SR_READY |=> !SR_READY [*3] ##1 SR_READY)
    else $error("ram tick not one in four");
  // ======
  // register bus answers
  write_answer_a: assert property (
    AWVALID && AWREADY && WVALID && WREADY && !BVALID |-> ##2 BVALID)
    else $error("late write response");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("late read data");
  resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  cover property (SR_VALID && SR_READY);
  cover property (BVALID && BRESP == emc_pkg::RESP_SLVERR);
  cover property ($rose(IRQ));
endmodule : emc_chk
bind emc_top emc_chk #(.BANKS(BANKS)) chk_i (.REF_CLK, .RESETN, .AWVALID, .AWREADY, .WVALID,
  .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .SR_VALID, .SR_READY,
  .LP_MODE, .DOMAIN_ON, .DOMAIN_ISO, .BANK_PWR_ON, .IRQ);
`default_nettype wire

// [emc_far_model.sv]
// interconnect-side master model for the slow on-chip ram port
`timescale 1ns/1ps
`default_nettype none
module emc_ram_master (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic wr_in,
  input wire logic [19:0] addr_in,
  input wire logic [63:0] data_in,
  input wire logic ready,
  output logic valid,
  output logic write,
  output logic [19:0] addr,
  output logic [63:0] data,
  output logic done
);
  // ======
  // request held until the slow tick takes it
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      valid <= 1'b0;
      write <= 1'b0;
      addr <= 20'h0;
      data <= 64'h0;
    end else if (valid && ready) begin // taken only on the divided tick
      valid <= 1'b0;
      done <= 1'b1;
      // released lines show no stale value
      write <= ~write;
      addr <= ~addr;
      data <= ~data;
    end else if (go && !valid) begin
      valid <= 1'b1;
      write <= wr_in;
      addr <= addr_in;
      data <= data_in;
    end
  end
endmodule : emc_ram_master
`default_nettype wire

// [ecc_multibit_error_capture_tb.sv]
// self-checking bench for the multi-bit ecc capture block
`timescale 1ns/1ps
`default_nettype none
module ecc_multibit_error_capture_tb;
  // ======
  // stimulus and observed nets
  logic clk = 1'b0; // 25 ns core clock
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ck = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] vld = 4'h0; // port strobes, bit 0 goes via the far model
  logic go = 1'b0, acc_wr = 1'b0, priv = 1'b0;
  logic [1:0] req = 2'h0, lp_mode = 2'h0;
  logic [19:0] acc_addr = 20'h0;
  logic [63:0] acc_data = 64'h0;
  wire logic awready, wready, bvalid, arready, rvalid, sr_valid, sr_ready, sr_write, done, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [19:0] sr_addr;
  wire logic [63:0] sr_data;
  wire logic [2:0] dom;
  wire logic [15:0] bank;
  wire logic [7:0] gen [4];
  int err_total = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  emc_top uut (
    .REF_CLK(clk), .RESETN(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .SR_VALID(sr_valid),
    .SR_READY(sr_ready), .SR_WRITE(sr_write), .SR_ADDR(sr_addr), .SR_DATA(sr_data),
    .SR_CHECK(ck), .SR_GEN_CHECK(gen[0]), .IC_VALID(vld[1]), .IC_WRITE(acc_wr),
    .IC_ADDR(acc_addr), .IC_DATA(acc_data), .IC_CHECK(ck), .IC_PRIV(priv), .IC_REQ(req),
    .IC_GEN_CHECK(gen[1]), .DCE_VALID(vld[2]), .DCE_WRITE(acc_wr), .DCE_ADDR(acc_addr),
    .DCE_DATA(acc_data[31:0]), .DCE_CHECK(ck), .DCE_PRIV(priv), .DCE_REQ(req),
    .DCE_GEN_CHECK(gen[2]), .DCO_VALID(vld[3]), .DCO_WRITE(acc_wr), .DCO_ADDR(acc_addr),
    .DCO_DATA(acc_data[31:0]), .DCO_CHECK(ck), .DCO_PRIV(priv), .DCO_REQ(req),
    .DCO_GEN_CHECK(gen[3]), .LP_MODE(lp_mode), .DOMAIN_ON(dom), .DOMAIN_ISO(),
    .BANK_PWR_ON(bank), .IRQ(irq));
  emc_ram_master far_i (.clk(clk), .rst_n(rst_n), .go(go), .wr_in(acc_wr), .addr_in(acc_addr),
    .data_in(acc_data), .ready(sr_ready), .valid(sr_valid), .write(sr_write), .addr(sr_addr),
    .data(sr_data), .done(done));
  // ======
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // write: address and data offered together, response must follow
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
    @(posedge clk); // gap before the next call
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
    chk(rdata, exp);
    @(posedge clk); // gap before the next call
  endtask : axr
  // one access on port c; port 0 waits for the far model's slow handshake
  task automatic inj(input int c, input logic [19:0] a, input logic [63:0] d,
                     input logic [7:0] k);
    int n;
    n = 0;
    acc_addr <= a;
    acc_data <= d;
    ck <= k;
    acc_wr <= c[1];
    priv <= c[0];
    req <= 2'(c - 1);
    if (c == 0) go <= 1'b1;
    else vld[c] <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    vld <= 4'h0;
    while (c == 0 && !done && n < 40) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask : inj
  // ======
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 6; i++) axr(8'(i * 4), i < 4 ? 32'h0 : 32'h7, 2'h0);
    axr(8'hF0, 32'h0, emc_pkg::RESP_SLVERR);
    axw(8'hF0, 32'h1, emc_pkg::RESP_SLVERR);
  endtask : t_reset
  // checking off: a four-bit error must leave no trace
  task automatic t_off;
    axw(8'h04, 32'hF, 2'h0);
    axw(8'h08, 32'hF, 2'h0);
    inj(1, 20'h00008, 64'h8000_0001_8000_0001, 8'h00);
    chk({23'h0, irq, gen[1]}, 32'h0);
    axr(8'h0C, 32'h0, 2'h0);
  endtask : t_off
  // every port: capture, info, interrupt, then write-one clear
  task automatic t_capture;
    logic [7:0] b;
    logic [31:0] e;
    axw(8'h00, 32'hF, 2'h0);
    for (int c = 0; c < 4; c++) begin
      b = 8'(8'h40 + c * 16);
      e = {26'h0, c == 1 ? emc_pkg::SIZE_64 : emc_pkg::SIZE_32, c[1], 2'(c - 1), c[0]};
      inj(c, 20'h12345, 64'h8000_0001_8000_0001, 8'h00);
      chk(32'(gen[c]), c < 2 ? 32'hC0 : 32'h21);
      chk({31'h0, irq}, 32'h1);
      axr(8'h0C, 32'(1 << c), 2'h0);
      axr(b, c < 2 ? 32'h12340 : 32'h12344, 2'h0);
      axr(b + 8'h4, 32'h8000_0001, 2'h0);
      axr(b + 8'h8, c < 2 ? 32'h8000_0001 : 32'h0, 2'h0);
      axr(b + 8'hC, c == 0 ? 32'h0 : e, 2'h0);
      axw(8'h0C, 32'h0, 2'h0);
      axr(8'h0C, 32'(1 << c), 2'h0);
      axw(8'h0C, 32'(1 << c), 2'h0);
      axr(8'h0C, 32'h0, 2'h0);
      chk({31'h0, irq}, 32'h0);
    end
  endtask : t_capture
  // status and capture gated separately; old capture must hold
  task automatic t_gate;
    axw(8'h04, 32'hD, 2'h0);
    axw(8'h08, 32'hB, 2'h0);
    inj(1, 20'h00100, 64'h0, 8'h03);
    inj(2, 20'h00200, 64'h6_0000_0006, 8'h00);
    axr(8'h0C, 32'h4, 2'h0);
    chk({31'h0, irq}, 32'h0);
    axr(8'h60, 32'h12344, 2'h0);
    axr(8'h64, 32'h8000_0001, 2'h0);
    axw(8'h0C, 32'h4, 2'h0);
  endtask : t_gate
  // every low-power mode under both control settings
  task automatic t_power;
    logic [2:0] e;
    for (int p = 0; p < 2; p++) begin
      axw(8'h10, p ? 32'h0 : 32'h7, 2'h0);
      for (int m = 0; m < 4; m++) begin
        lp_mode <= 2'(m);
        repeat (3) @(posedge clk);
        e = m == 3 ? 3'h0 : {m < 2 && p == 0, m < 2 || p == 0, 1'b1};
        chk({13'h0, bank, dom}, {13'h0, {8{e[2]}}, {7{e[1]}}, e[0], e});
        axr(8'h14, {29'h0, e}, 2'h0);
      end
    end
    lp_mode <= 2'h0;
  endtask : t_power
  // ======
  // verdict, main sequence, watchdog
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_off;
    t_capture;
    t_gate;
    t_power;
    end_sim;
  end
  // generous bound: the run needs a few hundred cycles
  initial begin
    #2_000_000;
    err_total++;
    end_sim;
  end
endmodule : ecc_multibit_error_capture_tb
`default_nettype wire
